// >>> csm_pkg.sv
// constants, types and register map of the configuration session handler
// assumes a front-end that splits each text message into typed fields
//
// Overview of operation
// R1 - only the session opener may close it; code commits on any close while a session is open
// R2 - close comes after all announced definitions
// R3 - only the creator deletes a configuration; code deletes on any delete naming a stored configuration
// R4 - deleting an name_not_found_code name returns an error
// R5 - names are 1 to 16 characters, unique
// R6 - any error message aborts the open session
// R7 - error carries source name and cause code
// R8 - name_not_found_code name or absent next gives name_not_found_code
// R9 - full stores or reused name refused
// R10 - per-category count mismatch gets its code
// R11 - bad definition content gets category code
// R12 - sub-channel definitions only inside session
// R13 - sub-channel defined before component references it
// R14 - sub-channel id, form and field ranges
// R15 - lengths in characters, numbers as decimal text
// R16 - stream definitions only inside session
// R17 - sender defines needed streams and spare slices
// R18 - sender states peak and average rates
// R19 - sender states packet protection and length
// R20 - announced rates kept for buffer sizing
// R21 - count definitions per category, check at close
package csm_pkg;
  localparam int NAME_CHARS = 16;
  localparam int NAME_W = 8 * NAME_CHARS;
  localparam int NCAT = 5;
  localparam int CNT_W = 14;
  localparam int RATE_W = 18;
  localparam int ADDR_W = 8;
  localparam logic [4:0] NAME_LEN_MIN = 5'h01;
  localparam logic [4:0] NAME_LEN_MAX = 5'h10;
  localparam logic [4:0] LEN_NEXT = 5'h04;
  localparam logic [4:0] LEN_CURRENT = 5'h07;
  // first character sits in the low byte
  localparam logic [NAME_W-1:0] NAME_NEXT = 128'h5458454e;
  localparam logic [NAME_W-1:0] NAME_CURRENT = 128'h544e4552525543;
  // ****************************************
  // sub-channel field limits
  // ****************************************
  localparam logic [7:0] SLICE_ID_MAX = 8'h3f;
  localparam logic [7:0] FORM_LONG = 8'h4c;
  localparam logic [7:0] FORM_SHORT = 8'h53;
  localparam logic [7:0] OPTION_MAX = 8'h07;
  localparam logic [7:0] PROT_MIN = 8'h01;
  localparam logic [7:0] PROT_MAX = 8'h04;
  localparam logic [9:0] SIZE_MIN = 10'h004;
  localparam logic [9:0] SIZE_MAX = 10'h360;
  localparam logic [7:0] TABLE_MAX = 8'h01;
  localparam logic [7:0] INDEX_MAX = 8'h3f;
  localparam logic [2:0] CAT_STREAM = 3'h1;
  localparam logic [2:0] CAT_COMPONENT = 3'h2;
  // ****************************************
  // register map
  // ****************************************
  localparam logic [ADDR_W-1:0] REG_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] REG_STATUS = 8'h04;
  localparam logic [ADDR_W-1:0] REG_ERROR = 8'h08;
  localparam logic [ADDR_W-1:0] REG_PEAK = 8'h0c;
  localparam logic [ADDR_W-1:0] REG_AVG = 8'h10;
  localparam int CTRL_NEXT_BIT = 0;
  localparam int STATUS_SESS_BIT = 0;
  localparam int STATUS_NEXT_BIT = 1;
  localparam int STATUS_STORE_LSB = 8;
  localparam int ERROR_COUNT_LSB = 16;
  typedef enum logic [3:0] {
    kind_open, kind_close, kind_delete, kind_request, kind_error,
    kind_slice, kind_stream, kind_component, kind_service, kind_figfile
  } csm_kind_t;
  typedef enum logic [3:0] {
    cause_none, name_not_found_code, stores_full_code, name_used_code,
    slice_count_bad_code, stream_count_bad_code, component_count_bad_code,
    service_count_bad_code, info_file_count_bad_code,
    slice_def_bad_code, stream_def_bad_code, component_def_bad_code,
    service_def_bad_code, info_file_def_bad_code
  } csm_cause_t;
endpackage

// >>> csm_handler.sv
// configuration session handler: recipient side of the definition exchange
// assumes messages arrive pre-decoded, one-cycle msg_valid, on clk_sys
`timescale 1ns/1ns
module csm_handler #(
  parameter int NSTORE = 4,
  parameter int ERRCNT_W = 16
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic nrst,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [csm_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // decoded incoming message
  input wire logic msg_valid,
  input wire csm_pkg::csm_kind_t msg_kind,
  input wire logic [csm_pkg::NAME_W-1:0] msg_name,
  input wire logic [4:0] msg_name_len,
  input wire logic [csm_pkg::NCAT*csm_pkg::CNT_W-1:0] msg_counts,
  input wire logic [7:0] msg_slice_id,
  input wire logic [7:0] msg_form,
  input wire logic [7:0] msg_field3,
  input wire logic [7:0] msg_field4,
  input wire logic [9:0] msg_size,
  input wire logic [7:0] msg_ref_slice,
  input wire logic [csm_pkg::RATE_W-1:0] msg_rate_peak,
  input wire logic [csm_pkg::RATE_W-1:0] msg_rate_avg,
  input wire logic msg_fields_ok,
  // outgoing error message
  output logic err_valid,
  output logic [csm_pkg::NAME_W-1:0] err_name,
  output csm_pkg::csm_cause_t err_cause,
  // answers and state
  output logic del_done,
  output logic req_hit,
  output logic session_open,
  output logic [NSTORE-1:0] store_used,
  output logic [csm_pkg::RATE_W-1:0] rate_peak,
  output logic [csm_pkg::RATE_W-1:0] rate_avg
);
  localparam int SLOT_W = (NSTORE > 1) ? $clog2(NSTORE) : 1;
  localparam int CW = csm_pkg::CNT_W;

  // ****************************************
  // state
  // ****************************************
  logic [NSTORE-1:0] used_ff;
  logic [csm_pkg::NAME_W-1:0] name_ff [NSTORE];
  logic [4:0] len_ff [NSTORE];
  logic [CW-1:0] ann_ff [csm_pkg::NCAT], rcv_ff [csm_pkg::NCAT];
  logic sess_ff, err_valid_ff, del_done_ff, req_hit_ff, next_pending_ff;
  logic [csm_pkg::NAME_W-1:0] sess_name_ff, err_name_ff;
  logic [4:0] sess_len_ff;
  logic [SLOT_W-1:0] sess_slot_ff;
  logic [63:0] seen_ff;
  csm_pkg::csm_cause_t err_cause_ff, last_cause_ff, cause;
  logic [ERRCNT_W-1:0] err_cnt_ff;
  logic [csm_pkg::RATE_W-1:0] peak_ff, avg_ff;
  logic [31:0] prdata_ff;

  // ****************************************
  // message decode
  // ****************************************
  logic [NSTORE-1:0] match;
  logic [csm_pkg::NCAT-1:0] mism;
  logic [SLOT_W-1:0] free_idx;
  logic [2:0] bad_cat;
  logic hit, free_any, cnt_bad, fire, open_go, commit, abort, bump, del_go, req_go;

  wire name_ok = msg_name_len >= csm_pkg::NAME_LEN_MIN
    && msg_name_len <= csm_pkg::NAME_LEN_MAX; // R5
  wire is_next = msg_name_len == csm_pkg::LEN_NEXT && msg_name == csm_pkg::NAME_NEXT;
  wire is_current = msg_name_len == csm_pkg::LEN_CURRENT
    && msg_name == csm_pkg::NAME_CURRENT;
  wire [2:0] cat_idx = 3'(msg_kind - csm_pkg::kind_slice);
  wire is_def = msg_kind >= csm_pkg::kind_slice;
  // numeric fields arrive already converted from decimal text
  wire long_ok = msg_field3 <= csm_pkg::OPTION_MAX
    && msg_field4 >= csm_pkg::PROT_MIN && msg_field4 <= csm_pkg::PROT_MAX
    && msg_size >= csm_pkg::SIZE_MIN && msg_size <= csm_pkg::SIZE_MAX; // R14 R15
  wire short_ok = msg_field3 <= csm_pkg::TABLE_MAX
    && msg_field4 <= csm_pkg::INDEX_MAX; // R14
  // a repeated slice id in one session counts as bad content
  wire slice_ok = msg_slice_id <= csm_pkg::SLICE_ID_MAX
    && !seen_ff[msg_slice_id[5:0]]
    && ((msg_form == csm_pkg::FORM_LONG && long_ok)
    || (msg_form == csm_pkg::FORM_SHORT && short_ok)); // R14
  wire ref_ok = msg_ref_slice <= csm_pkg::SLICE_ID_MAX
    && seen_ff[msg_ref_slice[5:0]]; // R13
  wire content_ok = (msg_kind == csm_pkg::kind_slice) ? slice_ok :
    (msg_kind == csm_pkg::kind_component) ? (msg_fields_ok && ref_ok) : msg_fields_ok;
  wire [3:0] def_cause = 4'(csm_pkg::slice_def_bad_code) + {1'b0, cat_idx};
  wire [3:0] cnt_cause = 4'(csm_pkg::slice_count_bad_code) + {1'b0, bad_cat};

  assign hit = |match;

  generate
    for (genvar s = 0; s < NSTORE; s++) begin : g_store
      assign match[s] = used_ff[s] && len_ff[s] == msg_name_len && name_ff[s] == msg_name;
      always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
          used_ff[s] <= 1'b0;
          name_ff[s] <= '0;
          len_ff[s] <= '0;
        end else if (commit && sess_slot_ff == SLOT_W'(s)) begin
          used_ff[s] <= 1'b1;
          name_ff[s] <= sess_name_ff;
          len_ff[s] <= sess_len_ff;
        end else if (del_go && match[s]) begin
          used_ff[s] <= 1'b0; // R3: any delete naming a stored configuration clears it, creator not checked
        end
      end
    end
    for (genvar c = 0; c < csm_pkg::NCAT; c++) begin : g_cat
      assign mism[c] = rcv_ff[c] != ann_ff[c]; // R21
      always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
          ann_ff[c] <= '0;
          rcv_ff[c] <= '0;
        end else if (open_go) begin
          ann_ff[c] <= msg_counts[c*CW +: CW]; // R15
          rcv_ff[c] <= '0;
        end else if (bump && cat_idx == 3'(c)) begin
          rcv_ff[c] <= rcv_ff[c] + CW'(1); // R21
        end
      end
    end
  endgenerate

  always_comb begin
    free_idx = '0;
    free_any = 1'b0;
    for (int i = NSTORE - 1; i >= 0; i--) begin
      if (!used_ff[i]) begin
        free_idx = SLOT_W'(i);
        free_any = 1'b1;
      end
    end
  end

  // lowest category wins when several counts are off
  always_comb begin
    cnt_bad = 1'b0;
    bad_cat = '0;
    for (int c = csm_pkg::NCAT - 1; c >= 0; c--) begin
      if (mism[c]) begin
        cnt_bad = 1'b1;
        bad_cat = 3'(c);
      end
    end
  end

  // ****************************************
  // message handling
  // ****************************************
  always_comb begin
    fire = 1'b0;
    cause = csm_pkg::cause_none;
    open_go = 1'b0;
    commit = 1'b0;
    abort = 1'b0;
    bump = 1'b0;
    del_go = 1'b0;
    req_go = 1'b0;
    if (msg_valid) begin
      case (msg_kind)
        csm_pkg::kind_open: begin
          if (sess_ff || !name_ok || is_next || is_current || hit) begin
            fire = 1'b1;
            cause = csm_pkg::name_used_code; // R9 R5
          end else if (!free_any) begin
            fire = 1'b1;
            cause = csm_pkg::stores_full_code; // R9
          end else begin
            open_go = 1'b1;
          end
        end
        csm_pkg::kind_close: begin
          // a close for a session the far side did not open is dropped
          if (sess_ff && cnt_bad) begin
            fire = 1'b1;
            cause = csm_pkg::csm_cause_t'(cnt_cause); // R10 R2
          end else if (sess_ff) begin
            commit = 1'b1; // R1: commits on any close while a session is open, close name not compared
          end
        end
        csm_pkg::kind_delete: begin
          if (!name_ok || !hit) begin
            fire = 1'b1;
            cause = csm_pkg::name_not_found_code; // R4 R8
          end else begin
            del_go = 1'b1;
          end
        end
        csm_pkg::kind_request: begin
          if ((is_next && next_pending_ff) || is_current || (name_ok && hit)) begin
            req_go = 1'b1;
          end else begin
            fire = 1'b1;
            cause = csm_pkg::name_not_found_code; // R8
          end
        end
        csm_pkg::kind_error: begin
          abort = 1'b1; // R6
        end
        default: begin
          if (is_def && (!sess_ff || !content_ok)) begin
            fire = 1'b1;
            cause = csm_pkg::csm_cause_t'(def_cause); // R11 R12 R16 R13
          end else if (is_def) begin
            bump = 1'b1;
          end
        end
      endcase
    end
  end

  wire own_name = msg_kind == csm_pkg::kind_open || msg_kind == csm_pkg::kind_delete
    || msg_kind == csm_pkg::kind_request;
  wire [csm_pkg::NAME_W-1:0] nxt_err_name = own_name ? msg_name : sess_name_ff; // R7
  wire sess_end = fire || abort || commit; // R6

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      sess_ff <= 1'b0;
      sess_name_ff <= '0;
      sess_len_ff <= '0;
      sess_slot_ff <= '0;
      seen_ff <= '0;
    end else if (open_go) begin
      sess_ff <= 1'b1;
      sess_name_ff <= msg_name;
      sess_len_ff <= msg_name_len;
      sess_slot_ff <= free_idx;
      seen_ff <= '0;
    end else begin
      if (sess_end) begin
        sess_ff <= 1'b0; // R6
      end
      if (bump && cat_idx == '0) begin
        seen_ff[msg_slice_id[5:0]] <= 1'b1; // R13
      end
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      err_valid_ff <= 1'b0;
      err_name_ff <= '0;
      err_cause_ff <= csm_pkg::cause_none;
      del_done_ff <= 1'b0;
      req_hit_ff <= 1'b0;
    end else begin
      err_valid_ff <= fire;
      del_done_ff <= del_go;
      req_hit_ff <= req_go;
      if (fire) begin
        err_name_ff <= nxt_err_name; // R7
        err_cause_ff <= cause;
      end
    end
  end

  // rates of the last accepted stream definition, for buffer sizing
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      peak_ff <= '0;
      avg_ff <= '0;
      last_cause_ff <= csm_pkg::cause_none;
      err_cnt_ff <= '0;
    end else begin
      if (bump && cat_idx == csm_pkg::CAT_STREAM) begin
        peak_ff <= msg_rate_peak; // R20
        avg_ff <= msg_rate_avg; // R20
      end
      if (fire) begin
        last_cause_ff <= cause;
        err_cnt_ff <= err_cnt_ff + ERRCNT_W'(1);
      end
    end
  end

  // ****************************************
  // apb registers
  // ****************************************
  wire setup = psel && !penable;
  wire access = psel && penable;
  wire sel_ctrl = paddr == csm_pkg::REG_CTRL;
  wire sel_status = paddr == csm_pkg::REG_STATUS;
  wire sel_error = paddr == csm_pkg::REG_ERROR;
  wire sel_peak = paddr == csm_pkg::REG_PEAK;
  wire sel_avg = paddr == csm_pkg::REG_AVG;
  wire mapped = sel_ctrl || sel_status || sel_error || sel_peak || sel_avg;
  wire [31:0] ctrl_word = 32'(next_pending_ff) << csm_pkg::CTRL_NEXT_BIT;
  wire [31:0] status_word = (32'(sess_ff) << csm_pkg::STATUS_SESS_BIT)
    | (32'(next_pending_ff) << csm_pkg::STATUS_NEXT_BIT)
    | (32'(used_ff) << csm_pkg::STATUS_STORE_LSB);
  wire [31:0] error_word = 32'(last_cause_ff)
    | (32'(err_cnt_ff) << csm_pkg::ERROR_COUNT_LSB);
  wire [31:0] rd_word = sel_ctrl ? ctrl_word : sel_status ? status_word :
    sel_error ? error_word : sel_peak ? 32'(peak_ff) : sel_avg ? 32'(avg_ff) : 32'h0;

  // read data captured in setup so it stands through the access phase
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      prdata_ff <= '0;
      next_pending_ff <= 1'b0;
    end else begin
      if (setup && !pwrite) begin
        prdata_ff <= rd_word;
      end
      if (access && pwrite && sel_ctrl) begin
        next_pending_ff <= pwdata[csm_pkg::CTRL_NEXT_BIT];
      end
    end
  end

  assign pready = 1'b1;
  assign pslverr = access && !mapped;
  assign prdata = prdata_ff;
  assign err_valid = err_valid_ff;
  assign err_name = err_name_ff;
  assign err_cause = err_cause_ff;
  assign del_done = del_done_ff;
  assign req_hit = req_hit_ff;
  assign session_open = sess_ff;
  assign store_used = used_ff;
  assign rate_peak = peak_ff;
  assign rate_avg = avg_ff;
endmodule

// >>> csm_handler_asserts.sv
// checker for the configuration session handler
// assumes it is bound onto csm_handler, one clock domain
`timescale 1ns/1ns
module csm_handler_asserts #(
  parameter int NSTORE = 4
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic nrst,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic [csm_pkg::ADDR_W-1:0] paddr,
  input wire logic pslverr,
  // messages and answers
  input wire logic msg_valid,
  input wire csm_pkg::csm_kind_t msg_kind,
  input wire logic err_valid,
  input wire csm_pkg::csm_cause_t err_cause,
  input wire logic del_done,
  input wire logic session_open,
  input wire logic [NSTORE-1:0] store_used
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  wire logic acc = psel && penable;
  wire logic mv_del = msg_valid && msg_kind == csm_pkg::kind_delete;
  wire logic idle = msg_valid && !session_open;
  a_unmapped_err: assert property (acc && paddr > 8'h10 |-> pslverr)
    else $error("unmapped access not refused");
  a_del_answer: assert property (mv_del |=> del_done != (err_valid &&
    err_cause == csm_pkg::name_not_found_code)) else $error("delete answer wrong");
  a_err_aborts: assert property (err_valid |-> !session_open)
    else $error("session survives error");
  a_err_in_quiet: assert property (msg_valid && msg_kind == csm_pkg::kind_error
    |=> !session_open && !err_valid) else $error("incoming error mishandled");
  a_close_idle: assert property (idle && msg_kind == csm_pkg::kind_close
    |=> !err_valid && $stable(store_used)) else $error("close outside session acted");
  a_slice_outside: assert property (idle && msg_kind == csm_pkg::kind_slice
    |=> err_valid && err_cause == csm_pkg::slice_def_bad_code) else $error("slice outside");
  a_stream_outside: assert property (idle && msg_kind == csm_pkg::kind_stream
    |=> err_valid && err_cause == csm_pkg::stream_def_bad_code) else $error("stream outside");
  a_cause_held: assert property (!err_valid |-> $stable(err_cause))
    else $error("cause changed without error");
  a_open_answer: assert property (idle && msg_kind == csm_pkg::kind_open
    |=> session_open != err_valid) else $error("open neither taken nor refused");
  c_delete: cover property (mv_del ##1 del_done);
  c_full: cover property (err_valid && err_cause == csm_pkg::stores_full_code);
  c_commit: cover property (session_open ##1 !session_open && !err_valid);
endmodule
bind csm_handler csm_handler_asserts #(.NSTORE(NSTORE)) csm_handler_asserts_inst (
  .clk_sys, .nrst, .psel, .penable, .paddr, .pslverr, .msg_valid, .msg_kind,
  .err_valid, .err_cause, .del_done, .session_open, .store_used);

// >>> csm_remote_model.sv
// far-side configuration entity issuing decoded messages
// assumes send is called from one process at a time
`timescale 1ns/1ns
module csm_remote_model (
  // clock
  input wire logic clk_sys,
  // message toward the handler
  output logic msg_valid,
  output csm_pkg::csm_kind_t msg_kind,
  output logic [csm_pkg::NAME_W-1:0] msg_name,
  output logic [4:0] msg_name_len,
  output logic [69:0] msg_counts,
  output logic [7:0] msg_slice_id,
  output logic [7:0] msg_form,
  output logic [7:0] msg_field3,
  output logic [7:0] msg_field4,
  output logic [9:0] msg_size,
  output logic [7:0] msg_ref_slice,
  output logic [17:0] msg_rate_peak,
  output logic [17:0] msg_rate_avg,
  output logic msg_fields_ok
);
  initial begin
    msg_valid = 1'b0;
    msg_kind = csm_pkg::kind_open;
    msg_name = '0;
    msg_name_len = 5'h01;
    msg_counts = '0;
    msg_slice_id = 8'h00;
    msg_form = 8'h00;
    msg_field3 = 8'h00;
    msg_field4 = 8'h00;
    msg_size = 10'h000;
    msg_ref_slice = 8'h00;
    msg_rate_peak = 18'h00000;
    msg_rate_avg = 18'h00000;
    msg_fields_ok = 1'b1;
  end
  // drives one message per call; the caller picks its name and when to close
  task send(input csm_pkg::csm_kind_t k, input logic [127:0] nm,
    input logic [4:0] ln, input logic [69:0] cn, input logic [7:0] id,
    input logic [7:0] fm, input logic [7:0] f3, input logic [7:0] f4, input logic [9:0] sz,
    input logic ok = 1'b1);
    @(posedge clk_sys);
    msg_valid <= 1'b1;
    msg_kind <= k;
    msg_name <= nm;
    msg_name_len <= ln;
    msg_counts <= cn;
    msg_slice_id <= id;
    msg_ref_slice <= id;
    msg_form <= fm;
    msg_field3 <= f3;
    msg_field4 <= f4;
    msg_size <= sz;
    msg_fields_ok <= ok;
    msg_rate_peak <= 18'h37aa0;
    msg_rate_avg <= 18'h1d4c0;
    @(posedge clk_sys);
    msg_valid <= 1'b0;
    // released name, counts and slice id show garbage; other fields keep the last value
    msg_name <= ~nm;
    msg_counts <= ~cn;
    msg_slice_id <= ~id;
    #1;
  endtask
endmodule

// >>> csm_handler_tb_top.sv
// self-checking bench for the configuration session handler
// assumes package, handler, checker and remote model compiled first
`timescale 1ns/1ns
module csm_handler_tb_top;
  logic clk_sys, nrst, psel, penable, pwrite, pready, pslverr, se;
  logic msg_valid, msg_fields_ok, err_valid, del_done, req_hit, session_open;
  logic [7:0] paddr, msg_slice_id, msg_form, msg_field3, msg_field4, msg_ref_slice;
  logic [31:0] pwdata, prdata, rd;
  csm_pkg::csm_kind_t msg_kind;
  csm_pkg::csm_cause_t err_cause;
  logic [127:0] msg_name, err_name;
  logic [4:0] msg_name_len;
  logic [69:0] msg_counts;
  logic [9:0] msg_size;
  logic [17:0] msg_rate_peak, msg_rate_avg, rate_peak, rate_avg;
  logic [3:0] store_used;
  int error_cnt = 0;
  int checks = 0;
  csm_handler csm_handler_inst (.clk_sys, .nrst, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .msg_valid, .msg_kind, .msg_name,
    .msg_name_len, .msg_counts, .msg_slice_id, .msg_form, .msg_field3, .msg_field4,
    .msg_size, .msg_ref_slice, .msg_rate_peak, .msg_rate_avg, .msg_fields_ok,
    .err_valid, .err_name, .err_cause, .del_done, .req_hit, .session_open,
    .store_used, .rate_peak, .rate_avg);
  csm_remote_model csm_remote_model_inst (.clk_sys, .msg_valid, .msg_kind, .msg_name,
    .msg_name_len, .msg_counts, .msg_slice_id, .msg_form, .msg_field3, .msg_field4,
    .msg_size, .msg_ref_slice, .msg_rate_peak, .msg_rate_avg, .msg_fields_ok);
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  task end_sim;
    $display("checks %0d mismatches %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task chk(input string nm, input logic [127:0] s, input logic [127:0] e);
    checks++;
    if (s !== e) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", nm, e, s);
    end
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do begin
      @(posedge clk_sys);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (pready !== 1'b1) begin
      error_cnt++;
      end_sim();
    end
    rd = prdata;
    se = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task m(input csm_pkg::csm_kind_t k, input logic [7:0] c = 8'h41,
    input logic [69:0] cn = 70'h0, input logic [7:0] id = 8'h00, input logic [7:0] fm = 8'h4c,
    input logic [7:0] f3 = 8'h00, input logic [7:0] f4 = 8'h01, input logic [9:0] sz = 10'h004);
    csm_remote_model_inst.send(k, {120'h0, c}, 5'h01, cn, id, fm, f3, f4, sz);
  endtask
  task mx(input csm_pkg::csm_kind_t k, input logic [127:0] nm, input logic [4:0] ln,
    input logic [69:0] cn = 70'h0, input logic ok = 1'b1);
    csm_remote_model_inst.send(k, nm, ln, cn, 8'h00, 8'h4c, 8'h00, 8'h01, 10'h004, ok);
  endtask
  task ex(input logic v, input csm_pkg::csm_cause_t c = csm_pkg::cause_none);
    chk("err_valid", err_valid, v);
    if (v) chk("err_cause", err_cause, c);
  endtask
  task t_regs;
    apb(1'b0, csm_pkg::REG_STATUS, 32'h0);
    chk("status", rd, 32'h0);
    apb(1'b1, csm_pkg::REG_CTRL, 32'h1);
    apb(1'b0, csm_pkg::REG_CTRL, 32'h0);
    chk("ctrl", rd, 32'h1);
    apb(1'b0, 8'h40, 32'h0);
    chk("slverr", se, 1'b1);
    chk("unmapped", rd, 32'h0);
    apb(1'b1, csm_pkg::REG_CTRL, 32'h0);
    $display("t_regs done");
  endtask
  task t_session;
    m(csm_pkg::kind_open, 8'h41, {28'h0, 14'h1, 14'h0, 14'h2});
    chk("open", session_open, 1'b1);
    m(csm_pkg::kind_slice, 8'h41, 70'h0, 8'h3f, 8'h4c, 8'h07, 8'h04, 10'h360);
    ex(1'b0);
    m(csm_pkg::kind_slice, 8'h41, 70'h0, 8'h05, 8'h53, 8'h01, 8'h3f);
    ex(1'b0);
    m(csm_pkg::kind_component, 8'h41, 70'h0, 8'h3f);
    ex(1'b0);
    m(csm_pkg::kind_close);
    ex(1'b0);
    chk("stores", store_used, 4'h1);
    m(csm_pkg::kind_open, 8'h42, {42'h0, 14'h2, 14'h0});
    m(csm_pkg::kind_stream, 8'h42);
    chk("peak", rate_peak, 18'h37aa0);
    chk("avg", rate_avg, 18'h1d4c0);
    m(csm_pkg::kind_close, 8'h42);
    ex(1'b1, csm_pkg::stream_count_bad_code);
    chk("aborted", session_open, 1'b0);
    $display("t_session done");
  endtask
  task t_full;
    for (int i = 0; i < 3; i++) begin
      m(csm_pkg::kind_open, 8'(8'h42 + i));
      m(csm_pkg::kind_close, 8'(8'h42 + i));
    end
    chk("stores", store_used, 4'hf);
    m(csm_pkg::kind_open, 8'h45);
    ex(1'b1, csm_pkg::stores_full_code);
    m(csm_pkg::kind_delete, 8'h41);
    chk("del_done", del_done, 1'b1);
    chk("stores", store_used, 4'he);
    m(csm_pkg::kind_delete, 8'h41);
    ex(1'b1, csm_pkg::name_not_found_code);
    chk("err_name", err_name, {120'h0, 8'h41});
    $display("t_full done");
  endtask
  task t_next;
    csm_remote_model_inst.send(csm_pkg::kind_request, csm_pkg::NAME_NEXT, csm_pkg::LEN_NEXT,
      70'h0, 8'h00, 8'h00, 8'h00, 8'h00, 10'h000);
    ex(1'b1, csm_pkg::name_not_found_code);
    apb(1'b1, csm_pkg::REG_CTRL, 32'h1);
    csm_remote_model_inst.send(csm_pkg::kind_request, csm_pkg::NAME_NEXT, csm_pkg::LEN_NEXT,
      70'h0, 8'h00, 8'h00, 8'h00, 8'h00, 10'h000);
    chk("req_hit", req_hit, 1'b1);
    $display("t_next done");
  endtask
  task t_bad;
    m(csm_pkg::kind_slice);
    ex(1'b1, csm_pkg::slice_def_bad_code);
    m(csm_pkg::kind_stream);
    ex(1'b1, csm_pkg::stream_def_bad_code);
    m(csm_pkg::kind_close);
    ex(1'b0);
    m(csm_pkg::kind_open, 8'h42);
    ex(1'b1, csm_pkg::name_used_code);
    m(csm_pkg::kind_open, 8'h46, 70'h1);
    m(csm_pkg::kind_error, 8'h46);
    chk("aborted", session_open, 1'b0);
    m(csm_pkg::kind_open, 8'h46, 70'h1);
    m(csm_pkg::kind_slice, 8'h46, 70'h0, 8'h01, 8'h53, 8'h02, 8'h00);
    ex(1'b1, csm_pkg::slice_def_bad_code);
    m(csm_pkg::kind_open, 8'h46, {28'h0, 14'h1, 28'h0});
    m(csm_pkg::kind_component, 8'h46, 70'h0, 8'h09);
    ex(1'b1, csm_pkg::component_def_bad_code);
    m(csm_pkg::kind_open, 8'h46, 70'h1);
    m(csm_pkg::kind_slice, 8'h46, 70'h0, 8'h01, 8'h4c, 8'h00, 8'h01, 10'h361);
    ex(1'b1, csm_pkg::slice_def_bad_code);
    apb(1'b0, csm_pkg::REG_ERROR, 32'h0);
    chk("error reg", rd, {16'h000a, 12'h0, csm_pkg::slice_def_bad_code});
    $display("t_bad done");
  endtask
  task t_names;
    mx(csm_pkg::kind_open, 128'h51, 5'h00);
    ex(1'b1, csm_pkg::name_used_code);
    mx(csm_pkg::kind_open, 128'h51, 5'h11);
    ex(1'b1, csm_pkg::name_used_code);
    mx(csm_pkg::kind_open, csm_pkg::NAME_CURRENT, csm_pkg::LEN_CURRENT);
    ex(1'b1, csm_pkg::name_used_code);
    mx(csm_pkg::kind_open, 128'h4847, 5'h02, {14'h1, 14'h1, 42'h0});
    mx(csm_pkg::kind_service, 128'h4847, 5'h02);
    ex(1'b0);
    m(csm_pkg::kind_close);
    ex(1'b1, csm_pkg::info_file_count_bad_code);
    mx(csm_pkg::kind_open, 128'h4847, 5'h02, {14'h1, 56'h0});
    mx(csm_pkg::kind_figfile, 128'h4847, 5'h02);
    m(csm_pkg::kind_close);
    ex(1'b0);
    chk("stores", store_used, 4'hf);
    mx(csm_pkg::kind_request, 128'h4847, 5'h02);
    chk("req_hit", req_hit, 1'b1);
    mx(csm_pkg::kind_request, csm_pkg::NAME_CURRENT, csm_pkg::LEN_CURRENT);
    chk("current", req_hit, 1'b1);
    mx(csm_pkg::kind_delete, 128'h4847, 5'h02);
    chk("del_done", del_done, 1'b1);
    mx(csm_pkg::kind_open, 128'h49, 5'h01, {42'h0, 14'h1, 14'h0});
    mx(csm_pkg::kind_stream, 128'h49, 5'h01, 70'h0, 1'b0);
    ex(1'b1, csm_pkg::stream_def_bad_code);
    chk("err_name", err_name, 128'h49);
    $display("t_names done");
  endtask
  task t_reset;
    @(posedge clk_sys);
    nrst <= 1'b0;
    repeat (2) @(posedge clk_sys);
    nrst <= 1'b1;
    @(posedge clk_sys);
    #1;
    chk("stores", store_used, 4'h0);
    chk("session", session_open, 1'b0);
    chk("cause", err_cause, csm_pkg::cause_none);
    chk("avg", rate_avg, 18'h0);
    apb(1'b0, csm_pkg::REG_CTRL, 32'h0);
    chk("ctrl", rd, 32'h0);
    m(csm_pkg::kind_delete, 8'h42);
    ex(1'b1, csm_pkg::name_not_found_code);
    $display("t_reset done");
  endtask
  initial begin
    nrst = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    repeat (2) @(posedge clk_sys);
    nrst <= 1'b1;
    t_regs();
    t_session();
    t_full();
    t_next();
    t_bad();
    t_names();
    t_reset();
    end_sim();
  end
endmodule
